/* File: afs_fault_status.sv */
`default_nettype none

// ==========================================================
// fault and status reporting for the eight input channels
module afs_fault_status
  import afs_pkg::*;
#(
  parameter int NCH = AFS_NCH
)
(
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [NCH-1:0][AFS_DW-1:0]           sample,
  input  wire logic                                 sample_valid,
  input  wire afs_chan_cfg_t [NCH-1:0]              cfg,
  input  wire logic [NCH-1:0][AFS_NALARM-1:0]       unlatch,
  input  wire afs_format_t                          data_format,
  input  wire afs_wiring_t                          wiring,
  input  wire logic                                 comm_fault,
  input  wire logic [NCH-1:0]                       calibrating,
  input  wire logic [NCH-1:0]                       cal_done,
  input  wire logic [NCH-1:0]                       cal_bad,
  output afs_report_t                               report
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [NCH-1:0]              cal_err;
    logic                        pend;
    logic [NCH-1:0][AFS_DW-1:0]  data_hold;
    afs_report_t                 report;
  } afs_top_st_t;

  afs_top_st_t                   st_q;
  afs_top_st_t                   st_d;

  wire afs_alarm_st_t [NCH-1:0]  ch_st;

  logic [NCH-1:0]                under_v;
  logic [NCH-1:0]                over_v;
  logic [15:0]                   used_mask;
  logic [15:0]                   range_vec;
  logic [15:0]                   cal_pat;
  logic [15:0]                   cfv;
  logic [15:0]                   mfw;
  logic [NCH-1:0][7:0]           status_w;
  logic [31:0]                   packed_w;
  logic                          any_calibrating;
  logic                          any_cal_err;
  logic                          is_float;

  // ==========================================================
  // per-channel alarm engines
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    afs_chan_alarm u_alarm (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample       (sample[g]),
      .sample_valid (sample_valid),
      .cfg          (cfg[g]),
      .unlatch      (unlatch[g]),
      .st_q         (ch_st[g])
    );
  end

  // ==========================================================
  // wiring dependent channel count and calibration pattern
  always_comb begin
    unique case (wiring)
      AFS_WIRE_DIFF: begin
        used_mask = 16'((1 << AFS_NCH_DIFF) - 1);
        cal_pat   = AFS_CFV_CAL_DIFF;
      end
      AFS_WIRE_HSD: begin
        used_mask = 16'((1 << AFS_NCH_HSD) - 1);
        cal_pat   = AFS_CFV_CAL_HSD;
      end
      AFS_WIRE_SE: begin
        used_mask = 16'((1 << AFS_NCH_SE) - 1);
        cal_pat   = AFS_CFV_CAL_SE;
      end
      // the spare code falls back to the widest wiring
      default: begin
        used_mask = 16'((1 << AFS_NCH_SE) - 1);
        cal_pat   = AFS_CFV_CAL_SE;
      end
    endcase
  end

  // ==========================================================
  // calibration error bits
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < NCH; i++) begin
      // a good result clears an earlier error, a bad one sets it
      if (cal_done[i]) begin
        st_d.cal_err[i] = cal_bad[i];
      end
    end
    st_d.report.valid = 1'b0;
    st_d.pend         = sample_valid;
    if (sample_valid) begin
      st_d.data_hold = sample;
    end
    // alarm flags settle one cycle after the sample strobe,
    // so the report is taken on the following cycle
    if (st_q.pend) begin
      st_d.report.valid                     = 1'b1;
      st_d.report.chan_data                 = st_q.data_hold;
      st_d.report.module_fault_summary_word = mfw;
      st_d.report.channel_fault_vector_word = cfv;
      st_d.report.per_channel_status_word   = status_w;
      st_d.report.packed_range_status_word  = packed_w;
    end
  end

  // ==========================================================
  // channel fault vector
  always_comb begin
    range_vec = AFS_WORD_RST;
    for (int i = 0; i < NCH; i++) begin
      under_v[i]   = ch_st[i].below_range_flag;
      over_v[i]    = ch_st[i].above_range_flag;
      range_vec[i] = under_v[i] | over_v[i];
    end
    any_calibrating = |calibrating;
    any_cal_err     = |st_q.cal_err;
    // communication loss outranks calibration
    if (comm_fault) begin
      cfv = AFS_CFV_COMM;
    end else if (any_calibrating) begin
      cfv = cal_pat;
    end else begin
      cfv = range_vec & used_mask;
    end
  end

  // ==========================================================
  // module fault summary word
  always_comb begin
    mfw               = AFS_WORD_RST;
    mfw[AFS_MF_GROUP] = |cfv;
    mfw[AFS_MF_CALNG] = any_calibrating;
    // summary holds in both formats
    mfw[AFS_MF_CALER] = any_cal_err;
  end

  // ==========================================================
  // per-channel and packed status words
  always_comb begin
    is_float = (data_format == AFS_FMT_FLOAT);
    packed_w = '0;
    for (int i = 0; i < NCH; i++) begin
      status_w[i] = 8'h00;
      if (is_float) begin
        status_w[i][AFS_ST_CALER] = st_q.cal_err[i];
        status_w[i][AFS_ST_UNDER] = under_v[i];
        status_w[i][AFS_ST_OVER]  = over_v[i];
        status_w[i][AFS_NALARM-1:0] = ch_st[i].alarm;
      end else begin
        // integer format carries range flags only
        packed_w[AFS_PK_UNDER - 2*i] = under_v[i];
        packed_w[AFS_PK_OVER - 2*i]  = over_v[i];
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign report = st_q.report;

endmodule

`default_nettype wire

/* File: afs_fault_status_sva.sv */
`default_nettype none
// ==========================================
// port checks for the fault and status block
module afs_fault_status_sva
  import afs_pkg::*;
#(
  parameter int NCH = AFS_NCH
)
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire logic           sample_valid,
  input wire afs_format_t    data_format,
  input wire afs_wiring_t    wiring,
  input wire logic           comm_fault,
  input wire logic [NCH-1:0] calibrating,
  input wire afs_report_t    report
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // comm_fault and calibrating are judged only when held over both capture cycles
  resp_lat_a: assert property (sample_valid |-> ##2 report.valid)
    else $error("report missing two cycles after sample");
  no_spur_a: assert property (report.valid |-> $past(sample_valid, 2))
    else $error("report without sample");
  group_bit_a: assert property (report.valid |->
    report.module_fault_summary_word[AFS_MF_GROUP] == (|report.channel_fault_vector_word))
    else $error("group bit disagrees with vector");
  unused_bits_a: assert property (report.valid |-> report.module_fault_summary_word[14:11] == 4'h0)
    else $error("unused module bits set");
  comm_vec_a: assert property (report.valid && $past(comm_fault) && $past(comm_fault, 2) |->
    report.channel_fault_vector_word == AFS_CFV_COMM)
    else $error("comm fault pattern wrong");
  cal_vec_a: assert property (report.valid && !$past(comm_fault) && !$past(comm_fault, 2)
    && (|$past(calibrating)) && (|$past(calibrating, 2)) |-> report.channel_fault_vector_word ==
    ($past(wiring) == AFS_WIRE_DIFF ? AFS_CFV_CAL_DIFF : $past(wiring) == AFS_WIRE_HSD ?
    AFS_CFV_CAL_HSD : AFS_CFV_CAL_SE))
    else $error("calibration pattern wrong");
  calng_bit_a: assert property (report.valid && (|$past(calibrating)) && (|$past(calibrating, 2)) |->
    report.module_fault_summary_word[AFS_MF_CALNG])
    else $error("calibrating bit missing");
  int_status_a: assert property (report.valid && $past(data_format) == AFS_FMT_INT
    && $past(data_format, 2) == AFS_FMT_INT |-> report.per_channel_status_word == '0)
    else $error("status words set in integer format");
  ch0_fault_a: assert property (report.valid && $past(data_format) == AFS_FMT_FLOAT && !$past(comm_fault)
    && !$past(comm_fault, 2) && $past(calibrating) == '0 && $past(calibrating, 2) == '0 |->
    report.channel_fault_vector_word[0] == (report.per_channel_status_word[0][AFS_ST_UNDER]
    | report.per_channel_status_word[0][AFS_ST_OVER]))
    else $error("channel 0 fault bit disagrees with range bits");
endmodule

bind afs_fault_status afs_fault_status_sva #(.NCH(NCH)) afs_fault_status_sva_inst (
  .clk(clk), .rst_n(rst_n), .sample_valid(sample_valid), .data_format(data_format), .wiring(wiring),
  .comm_fault(comm_fault), .calibrating(calibrating), .report(report));
`default_nettype wire

/* File: afs_fault_status_tb_top.sv */
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, g, x); end end
module afs_fault_status_tb_top
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                               clk, rst_n, sample_valid, drop, comm_fault, got, prim;
  logic [AFS_NCH-1:0][AFS_DW-1:0]     sample;
  afs_chan_cfg_t [AFS_NCH-1:0]        cfg;
  logic [AFS_NCH-1:0][AFS_NALARM-1:0] unlatch;
  afs_format_t                        data_format;
  afs_wiring_t                        wiring;
  logic [AFS_NCH-1:0]                 calibrating, cal_done, cal_bad, ce;
  afs_report_t                        report, words, e, e2;
  afs_report_t                        q[$];
  logic [AFS_NALARM-1:0]              al[AFS_NCH];
  int                                 pv[AFS_NCH];
  int                                 n_fail = 0;
  int                                 checked = 0;

  afs_fault_status afs_fault_status_inst (.clk(clk), .rst_n(rst_n), .sample(sample), .sample_valid(sample_valid),
    .cfg(cfg), .unlatch(unlatch), .data_format(data_format), .wiring(wiring), .comm_fault(comm_fault),
    .calibrating(calibrating), .cal_done(cal_done), .cal_bad(cal_bad), .report(report));
  afs_owner_model afs_owner_model_inst (.clk(clk), .rst_n(rst_n), .report(report), .drop(drop),
    .comm_fault(comm_fault), .got(got), .words(words));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // reference model and drivers
  function automatic logic upd(logic cur, logic set, logic clr);
    return set | (cur & !(clr & !cfg[0].latch_en));
  endfunction

  task automatic idle(int k);
    repeat (k) begin
      @(posedge clk);
      sample_valid <= 1'b0;
      unlatch <= '0;
      cal_done <= '0;
    end
  endtask

  task automatic samp();
    int x, d, lim;
    logic un, ov;
    @(posedge clk);
    e = '0;
    e.valid = 1'b1;
    lim = wiring == AFS_WIRE_DIFF ? 4 : wiring == AFS_WIRE_HSD ? 2 : 8;
    for (int n = 0; n < AFS_NCH; n++) begin
      x = int'($urandom_range(5000)) - 2500;
      sample[n] <= AFS_DW'(x);
      un = x <= -2000;
      ov = x >= 2000;
      d = x > pv[n] ? x - pv[n] : pv[n] - x;
      al[n][4] = upd(al[n][4], prim && d > 3000, d < 3000);
      al[n][3] = upd(al[n][3], x < -500, x > -450);
      al[n][2] = upd(al[n][2], x > 500, x < 450);
      al[n][1] = upd(al[n][1], x < -1000, x > -950);
      al[n][0] = upd(al[n][0], x > 1000, x < 950);
      pv[n] = x;
      e.chan_data[n] = AFS_DW'(x);
      if (data_format == AFS_FMT_FLOAT) e.per_channel_status_word[n] = {ce[n], un, ov, al[n]};
      else e.packed_range_status_word[31-2*n -: 2] = {un, ov};
      e.channel_fault_vector_word[n] = (un | ov) && (n < lim);
    end
    prim = 1'b1;
    if (|calibrating) e.channel_fault_vector_word = lim == 4 ? 16'h000f : lim == 2 ? 16'h0003 : 16'h00ff;
    if (drop) e.channel_fault_vector_word = 16'hffff;
    e.module_fault_summary_word = {|e.channel_fault_vector_word, 4'h0, |calibrating, |ce, 9'h000};
    sample_valid <= 1'b1;
    q.push_back(e);
  endtask

  // quiet gap first so a pending report is built from settled controls
  task automatic ctl(afs_format_t f, afs_wiring_t w, logic [7:0] c, logic dr, logic l);
    idle(3);
    data_format <= f;
    wiring <= w;
    calibrating <= c;
    drop <= dr;
    for (int n = 0; n < AFS_NCH; n++) cfg[n].latch_en <= l;
    idle(4);
  endtask

  task automatic calp(logic [7:0] b);
    idle(3);
    // idle has just lowered the strobe in this step, so let an edge pass
    @(posedge clk);
    cal_done <= 8'hff;
    cal_bad <= b;
    ce = b;
    idle(3);
  endtask

  task automatic unl(logic [AFS_NALARM-1:0] m);
    idle(3);
    @(posedge clk);
    unlatch <= {AFS_NCH{m}};
    foreach (al[n]) al[n] = al[n] & ~m;
    idle(3);
  endtask

  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // scoreboard on what the owner received
  always @(posedge clk) begin
    if (got === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) begin
        e2 = q.pop_front();
        `CHK(words.chan_data, e2.chan_data)
        `CHK(words.module_fault_summary_word, e2.module_fault_summary_word)
        `CHK(words.channel_fault_vector_word, e2.channel_fault_vector_word)
        `CHK(words.per_channel_status_word, e2.per_channel_status_word)
        `CHK(words.packed_range_status_word, e2.packed_range_status_word)
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    unlatch = '0;
    data_format = AFS_FMT_FLOAT;
    wiring = AFS_WIRE_SE;
    calibrating = '0;
    cal_done = '0;
    cal_bad = '0;
    drop = 1'b0;
    ce = '0;
    prim = 1'b0;
    foreach (al[n]) begin
      al[n] = '0;
      pv[n] = 0;
      cfg[n] = '{16'sd1000, 16'sd500, -16'sd500, -16'sd1000, -16'sd2000, 16'sd2000, 16'd50, 16'd3000, 1'b0};
    end
    void'($urandom(32'h9a27));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) samp();
    ctl(AFS_FMT_FLOAT, AFS_WIRE_SE, 8'h00, 1'b0, 1'b1);
    repeat (4) begin
      samp();
      idle(2);
    end
    unl(5'h0a);
    samp();
    unl(5'h15);
    repeat (3) samp();
    ctl(AFS_FMT_FLOAT, AFS_WIRE_SE, 8'h00, 1'b0, 1'b0);
    calp(8'h05);
    samp();
    calp(8'h04);
    for (int w = 0; w < 4; w++) begin
      ctl(AFS_FMT_FLOAT, afs_wiring_t'(w[1:0]), 8'h02, 1'b0, 1'b0);
      samp();
      ctl(AFS_FMT_FLOAT, afs_wiring_t'(w[1:0]), 8'h00, 1'b0, 1'b0);
      repeat (2) samp();
    end
    ctl(AFS_FMT_FLOAT, AFS_WIRE_HSD, 8'h01, 1'b1, 1'b0);
    samp();
    ctl(AFS_FMT_INT, AFS_WIRE_SE, 8'h00, 1'b0, 1'b0);
    repeat (3) samp();
    ctl(AFS_FMT_INT, AFS_WIRE_DIFF, 8'h01, 1'b0, 1'b0);
    samp();
    idle(6);
    `CHK(q.size(), 0)
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire

/* File: afs_owner_model.sv */
`default_nettype none
// ==========================================
// owner controller: link state and received words
module afs_owner_model
  import afs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire afs_report_t report,
  input  wire logic        drop,
  output var logic         comm_fault,
  output var logic         got,
  output afs_report_t      words
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comm_fault <= 1'b0;
      got        <= 1'b0;
      words      <= '0;
    end else begin
      comm_fault <= drop;
      got        <= report.valid;
      if (report.valid) begin
        words <= report;
      end
    end
  end
endmodule
`default_nettype wire

/* File: afs_pkg.sv */
// Functional notes
// - float format: under or over range sets that channel's fault vector bit.
// - any channel calibration error sets module fault word bit 9.
// - bad calibration result sets the channel calibration error bit 7.
// - under-range bit 6 set while input at or below minimum detectable.
// - over-range bit 5 set while input at or above maximum detectable.
// - rate alarm bit 4 set above rate limit, cleared below it.
// - low alarm bit 3 set below low limit, cleared above trigger point.
// - high alarm bit 2 set above high limit, cleared below trigger point.
// - low-low alarm bit 1 set below its limit, cleared above trigger point.
// - high-high alarm bit 0 set above its limit, cleared below trigger point.
// - latched alarms stay set until the controller unlatches them.
// - limit alarms stay set while input stays inside the deadband.
// - module fault bit 15 set when any channel fault vector bit set.
// - bit 10 set while calibrating; channel fault vector then forced set.
// - calibration vector reads 00ff, 000f or 0003 by wiring.
// - communication fault forces channel fault vector to ffff.
// - channel n maps to vector bit n; 8, 4 or 2 channels by wiring.
// - module fault word bits 11 to 14 always zero.
// - integer format: range flags only, packed into one 32-bit word.
// - integer word: under at bit 31-2n, over at bit 30-2n.
// - integer format still reports calibration error summary bit.
// - status words are delivered together with each channel data transfer.
`default_nettype none

package afs_pkg;

  // ==========================================================
  // sizes and bit positions
  localparam int AFS_NCH      = 8;
  localparam int AFS_DW       = 16;
  localparam int AFS_ST_CALER = 7;
  localparam int AFS_ST_UNDER = 6;
  localparam int AFS_ST_OVER  = 5;
  localparam int AFS_NALARM   = 5;
  localparam int AFS_MF_GROUP = 15;
  localparam int AFS_MF_CALNG = 10;
  localparam int AFS_MF_CALER = 9;
  localparam int AFS_PK_UNDER = 31;
  localparam int AFS_PK_OVER  = 30;
  localparam int AFS_NCH_SE   = 8;
  localparam int AFS_NCH_DIFF = 4;
  localparam int AFS_NCH_HSD  = 2;

  // ==========================================================
  // fixed vector patterns and reset values
  localparam logic [15:0] AFS_CFV_CAL_SE   = 16'h00ff;
  localparam logic [15:0] AFS_CFV_CAL_DIFF = 16'h000f;
  localparam logic [15:0] AFS_CFV_CAL_HSD  = 16'h0003;
  localparam logic [15:0] AFS_CFV_COMM     = 16'hffff;
  localparam logic [15:0] AFS_WORD_RST     = 16'h0000;

  typedef enum logic [1:0] {
    AFS_WIRE_SE   = 2'b00,
    AFS_WIRE_DIFF = 2'b01,
    AFS_WIRE_HSD  = 2'b11
  } afs_wiring_t;

  typedef enum logic {
    AFS_FMT_INT   = 1'b0,
    AFS_FMT_FLOAT = 1'b1
  } afs_format_t;

  typedef struct packed {
    logic signed [AFS_DW-1:0] high_high_limit;
    logic signed [AFS_DW-1:0] high_limit;
    logic signed [AFS_DW-1:0] low_limit;
    logic signed [AFS_DW-1:0] low_low_limit;
    logic signed [AFS_DW-1:0] min_detect;
    logic signed [AFS_DW-1:0] max_detect;
    logic        [AFS_DW-1:0] deadband;
    logic        [AFS_DW-1:0] rate_limit;
    logic                     latch_en;
  } afs_chan_cfg_t;

  // alarm order: rate, low, high, low-low, high-high (bits 4..0)
  typedef struct packed {
    logic signed [AFS_DW-1:0] prev;
    logic                     primed;
    logic [AFS_NALARM-1:0]    alarm;
    logic                     below_range_flag;
    logic                     above_range_flag;
  } afs_alarm_st_t;

  typedef struct packed {
    logic                               valid;
    logic [AFS_NCH-1:0][AFS_DW-1:0]     chan_data;
    logic [15:0]                        module_fault_summary_word;
    logic [15:0]                        channel_fault_vector_word;
    logic [AFS_NCH-1:0][7:0]            per_channel_status_word;
    logic [31:0]                        packed_range_status_word;
  } afs_report_t;

endpackage

// ==========================================================
// per-channel range, rate and limit alarm evaluation
module afs_chan_alarm
  import afs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [AFS_DW-1:0]     sample,
  input  wire logic                  sample_valid,
  input  wire afs_chan_cfg_t         cfg,
  input  wire logic [AFS_NALARM-1:0] unlatch,
  output afs_alarm_st_t              st_q
);

  afs_alarm_st_t           st_d;
  logic signed [17:0]      x;
  logic signed [17:0]      db;
  logic signed [17:0]      diff;
  logic signed [17:0]      mag;
  logic [AFS_NALARM-1:0]   set_c;
  logic [AFS_NALARM-1:0]   clr_c;
  logic [AFS_NALARM-1:0]   rel;

  function automatic logic signed [17:0] ext(input logic [AFS_DW-1:0] v);
    ext = 18'(signed'(v));
  endfunction

  always_comb begin
    st_d = st_q;
    x    = ext(sample);
    db   = signed'({2'b00, cfg.deadband});
    diff = x - ext(st_q.prev);
    mag  = diff[17] ? -diff : diff;
    // first sample has no history, so no rate is judged on it
    set_c[4] = st_q.primed && (mag > signed'({2'b00, cfg.rate_limit}));
    clr_c[4] = !st_q.primed || (mag < signed'({2'b00, cfg.rate_limit}));
    set_c[3] = x < ext(cfg.low_limit);
    clr_c[3] = x > ext(cfg.low_limit) + db;
    set_c[2] = x > ext(cfg.high_limit);
    clr_c[2] = x < ext(cfg.high_limit) - db;
    set_c[1] = x < ext(cfg.low_low_limit);
    clr_c[1] = x > ext(cfg.low_low_limit) + db;
    set_c[0] = x > ext(cfg.high_high_limit);
    clr_c[0] = x < ext(cfg.high_high_limit) - db;
    // unlatch acts at once; a set in the same cycle still wins
    rel = cfg.latch_en ? unlatch : (clr_c & {AFS_NALARM{sample_valid}});
    st_d.alarm = (set_c & {AFS_NALARM{sample_valid}}) | (st_q.alarm & ~rel);
    if (sample_valid) begin
      st_d.prev             = sample;
      st_d.primed           = 1'b1;
      st_d.below_range_flag = x <= ext(cfg.min_detect);
      st_d.above_range_flag = x >= ext(cfg.max_detect);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire
